// ### shared/dmr_pkg.sv
// Purpose: Shared constants and types for the reference path controller.
// Assumes: One 40 MHz system clock; all control bits arrive as plain ports.
// Notes: Codes and reset values for the design files, gathered in one package.
package dmr_pkg;
  // ----------------------------------------------------------------------
  // Phase slope limit codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] DMR_SLOPE_61US = 3'h0;
  localparam logic [2:0] DMR_SLOPE_885NS = 3'h1;
  localparam logic [2:0] DMR_SLOPE_7U5 = 3'h2;
  localparam logic [2:0] DMR_SLOPE_UNLIM = 3'h3;
  localparam logic [2:0] DMR_SLOPE_1NS = 3'h4;
  localparam logic [2:0] DMR_SLOPE_5NS = 3'h5;
  localparam logic [2:0] DMR_SLOPE_10NS = 3'h6;
  localparam logic [2:0] DMR_SLOPE_PROG = 3'h7;
  localparam logic [2:0] DMR_SLOPE_RESET = DMR_SLOPE_PROG;
  localparam logic [23:0] DMR_PROG_RATE_RESET = 24'h000000;
  // ----------------------------------------------------------------------
  // Secondary PLL mode field codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] DMR_MODE_AUTO = 3'h0;
  localparam logic [2:0] DMR_MODE_FREE = 3'h1;
  localparam logic [2:0] DMR_MODE_HOLD = 3'h2;
  localparam logic [2:0] DMR_MODE_LOCK = 3'h4;
  localparam logic DMR_PDN_RESET = 1'h1;
  // ----------------------------------------------------------------------
  // Reference frequency codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] DMR_FREQ_8K = 4'h0;
  localparam logic [3:0] DMR_FREQ_T1E1 = 4'h1;
  localparam logic [3:0] DMR_FREQ_6M48 = 4'h2;
  localparam logic [3:0] DMR_FREQ_2K = 4'h9;
  localparam logic [3:0] DMR_FREQ_4K = 4'hA;
  localparam logic [3:0] DMR_FREQ_1PPS = 4'hB;
  localparam logic [3:0] DMR_FREQ_6M25 = 4'hC;
  // ----------------------------------------------------------------------
  // High-frequency divider codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] DMR_HF_BYPASS = 2'h0;
  localparam logic [1:0] DMR_HF_DIV4 = 2'h1;
  localparam logic [1:0] DMR_HF_DIV5 = 2'h2;
  // ----------------------------------------------------------------------
  // Secondary PLL automatic states, Gray coded
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DMR_ST_FREE = 2'h0,
    DMR_ST_LOCK = 2'h1,
    DMR_ST_HOLD = 2'h3
  } dmr_state_t;
endpackage : dmr_pkg

// ### verilog/dmr_slope_limiter.sv
// Purpose: Limit the rate of output phase movement of the primary PLL.
// Assumes: Phase in signed fixed units; one step budget per clock.
// Notes: Step budget per code is a case table in relative units, fixed except the programmable code.
`timescale 1ns/1ps
`default_nettype none
module dmr_slope_limiter #(
  parameter int PW = 24
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Control
  input wire logic [2:0] sel_i,
  input wire logic [23:0] prog_rate_i,
  // Phase
  input wire logic signed [PW-1:0] target_i,
  output logic signed [PW-1:0] phase_o
);
  // ----------------------------------------------------------------------
  // Step budget per code
  // ----------------------------------------------------------------------
  // Budgets are relative units; zero programmable rate freezes movement.
  function automatic logic [23:0] step_of(input logic [2:0] s,
                                          input logic [23:0] p);
    unique case (s)
      dmr_pkg::DMR_SLOPE_61US: step_of = 24'h00003D;
      dmr_pkg::DMR_SLOPE_885NS: step_of = 24'h000001;
      dmr_pkg::DMR_SLOPE_7U5: step_of = 24'h000008;
      dmr_pkg::DMR_SLOPE_UNLIM: step_of = 24'h000578;
      dmr_pkg::DMR_SLOPE_1NS: step_of = 24'h000001;
      dmr_pkg::DMR_SLOPE_5NS: step_of = 24'h000001;
      dmr_pkg::DMR_SLOPE_10NS: step_of = 24'h000001;
      dmr_pkg::DMR_SLOPE_PROG: step_of = p;
    endcase
  endfunction : step_of

  wire logic [23:0] step = step_of(sel_i, prog_rate_i);
  wire logic signed [PW:0] diff = PW'(target_i) - PW'(phase_o);
  wire logic signed [PW:0] stp = {{(PW-23){1'b0}}, step};
  wire logic signed [PW:0] delta = (diff > stp) ? stp :
                                   (diff < -stp) ? -stp : diff;
  wire logic signed [PW-1:0] phase_nxt = phase_o + delta[PW-1:0];

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_o <= '0;
    end else begin
      phase_o <= phase_nxt;
    end
  end
endmodule : dmr_slope_limiter
`default_nettype wire

// ### verilog/dmr_secondary_mode.sv
// Purpose: Secondary PLL operating mode and holdover frequency choice.
// Assumes: Reference selection and qualification come from outside.
// Notes: Averaging filter is a simple leaky integrator.
`timescale 1ns/1ps
`default_nettype none
module dmr_secondary_mode #(
  parameter int FW = 24,
  parameter int AVG_SHIFT = 12
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Control
  input wire logic [2:0] mode_sel_i,
  input wire logic power_down_i,
  input wire logic averaging_i,
  // Reference status
  input wire logic ref_selected_i,
  input wire logic ref_disqualified_i,
  input wire logic ref_preempted_i,
  input wire logic ref_forced_move_i,
  input wire logic signed [FW-1:0] integral_freq_i,
  // Results
  output logic [1:0] state_o,
  output logic leave_ref_o,
  output logic signed [FW-1:0] hold_freq_o
);
  dmr_pkg::dmr_state_t st_r;
  dmr_pkg::dmr_state_t st_nxt;
  logic signed [FW-1:0] avg_r;
  logic signed [FW-1:0] last_r;

  wire logic leave = (st_r == dmr_pkg::DMR_ST_LOCK) &&
    (ref_disqualified_i || ref_preempted_i || ref_forced_move_i);
  wire logic is_auto = (mode_sel_i == dmr_pkg::DMR_MODE_AUTO);
  wire logic signed [FW-1:0] avg_nxt =
    avg_r + ((integral_freq_i - avg_r) >>> AVG_SHIFT);

  always_comb begin
    st_nxt = st_r;
    if (power_down_i) begin
      st_nxt = dmr_pkg::DMR_ST_FREE;
    end else if (!is_auto) begin
      unique case (mode_sel_i)
        dmr_pkg::DMR_MODE_HOLD: st_nxt = dmr_pkg::DMR_ST_HOLD;
        dmr_pkg::DMR_MODE_LOCK: st_nxt = dmr_pkg::DMR_ST_LOCK;
        default: st_nxt = dmr_pkg::DMR_ST_FREE;
      endcase
    end else begin
      unique case (st_r)
        dmr_pkg::DMR_ST_FREE:
          st_nxt = ref_selected_i ? dmr_pkg::DMR_ST_LOCK : st_r;
        dmr_pkg::DMR_ST_LOCK:
          st_nxt = (!ref_selected_i || leave) ? dmr_pkg::DMR_ST_HOLD : st_r;
        dmr_pkg::DMR_ST_HOLD:
          st_nxt = ref_selected_i ? dmr_pkg::DMR_ST_LOCK : st_r;
        default: st_nxt = dmr_pkg::DMR_ST_FREE;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= dmr_pkg::DMR_ST_FREE;
      avg_r <= '0;
      last_r <= '0;
      leave_ref_o <= 1'b0;
      hold_freq_o <= '0;
    end else begin
      st_r <= st_nxt;
      leave_ref_o <= leave && is_auto;
      if (st_r == dmr_pkg::DMR_ST_LOCK) begin
        last_r <= integral_freq_i;
        avg_r <= avg_nxt;
      end
      hold_freq_o <= averaging_i ? avg_r : last_r;
    end
  end

  assign state_o = st_r;
endmodule : dmr_secondary_mode
`default_nettype wire

// ### verilog/dmr_ref_path.sv
// Purpose: Reference path control: seamless switching, slope limit,
//          secondary PLL modes and input pre-divider configuration.
// Assumes: Inputs synchronous to clock_i; PLL datapaths live elsewhere.
// Notes: Control and status are plain ports, no register bus.
`timescale 1ns/1ps
`default_nettype none
module dmr_ref_path #(
  parameter int NIN = 14,
  parameter int PW = 24,
  parameter int FW = 24
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Primary PLL seamless switching
  input wire logic seamless_enable_i,
  input wire logic seamless_freeze_i,
  input wire logic [3:0] primary_ref_i,
  input wire logic primary_in_holdover_i,
  input wire logic primary_in_free_run_i,
  input wire logic signed [PW-1:0] ref_phase_i,
  output logic seamless_switch_event_o,
  output logic signed [PW-1:0] compensation_o,
  output logic signed [PW-1:0] output_phase_o,
  // Slope limit configuration
  input wire logic slope_write_i,
  input wire logic [2:0] phase_rate_limit_select_i,
  input wire logic prog_write_i,
  input wire logic [23:0] programmable_phase_rate_value_i,
  output logic [2:0] slope_select_o,
  output logic [23:0] prog_rate_o,
  // Secondary PLL
  input wire logic [2:0] secondary_mode_select_i,
  input wire logic pdn_write_i,
  input wire logic secondary_power_down_i,
  input wire logic secondary_holdover_averaging_i,
  input wire logic ref_selected_i,
  input wire logic ref_disqualified_i,
  input wire logic ref_preempted_i,
  input wire logic ref_forced_move_i,
  input wire logic signed [FW-1:0] integral_freq_i,
  output logic secondary_power_down_o,
  output logic [1:0] secondary_state_o,
  output logic secondary_leave_ref_o,
  output logic signed [FW-1:0] secondary_hold_freq_o,
  // Composite clock inputs
  input wire logic composite_low_tone_select_i,
  input wire logic [1:0] composite_bad_i,
  input wire logic [1:0] violation_clear_i,
  input wire logic [1:0] violation_mask_i,
  output logic composite_a_violation_flag_o,
  output logic composite_b_violation_flag_o,
  output logic composite_low_tone_o,
  output logic interrupt_o,
  // Per-input configuration write port
  input wire logic cfg_write_i,
  input wire logic [3:0] cfg_input_i,
  input wire logic [2:0] cfg_field_i,
  input wire logic [15:0] cfg_data_i,
  // Per-input configuration read port
  input wire logic [3:0] rd_input_i,
  output logic [3:0] sync_source_o,
  output logic [1:0] sync_freq_o,
  output logic [3:0] freq_code_o,
  output logic freq_reserved_o,
  output logic [1:0] high_freq_divide_select_o,
  output logic [14:0] integer_divide_factor_o,
  output logic prediv_bypass_o,
  output logic [15:0] frac_num_o,
  output logic [15:0] frac_den_o
);
  // ----------------------------------------------------------------------
  // Field selectors on the per-input write port
  // ----------------------------------------------------------------------
  localparam logic [2:0] F_SYNC = 3'h0;
  localparam logic [2:0] F_FREQ = 3'h1;
  localparam logic [2:0] F_HFDIV = 3'h2;
  localparam logic [2:0] F_DIVLO = 3'h3;
  localparam logic [2:0] F_DIVHI = 3'h4;
  localparam logic [2:0] F_NUM = 3'h5;
  localparam logic [2:0] F_DEN = 3'h6;
  localparam logic [2:0] F_BYP = 3'h7;

  // ----------------------------------------------------------------------
  // Seamless switching
  // ----------------------------------------------------------------------
  logic [3:0] prev_ref_r;
  logic prev_idle_r;
  logic signed [PW-1:0] comp_r;
  wire logic idle_now = primary_in_holdover_i || primary_in_free_run_i;
  wire logic trig = seamless_enable_i &&
    ((primary_ref_i != prev_ref_r) || (prev_idle_r && !idle_now));
  wire logic take = trig && !seamless_freeze_i;
  // Limiter steers toward the compensated reference; the raw reference when disabled.
  wire logic signed [PW-1:0] target =
    seamless_enable_i ? ref_phase_i - comp_r : ref_phase_i;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_ref_r <= 4'h0;
      prev_idle_r <= 1'b1;
      comp_r <= '0;
      seamless_switch_event_o <= 1'b0;
    end else begin
      prev_ref_r <= primary_ref_i;
      prev_idle_r <= idle_now;
      seamless_switch_event_o <= take;
      if (take) begin
        comp_r <= ref_phase_i - output_phase_o;
      end else if (!seamless_enable_i) begin
        comp_r <= '0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Slope limit configuration
  // ----------------------------------------------------------------------
  logic [2:0] slope_r;
  logic [23:0] prog_r;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      slope_r <= dmr_pkg::DMR_SLOPE_RESET;
      prog_r <= dmr_pkg::DMR_PROG_RATE_RESET;
    end else begin
      if (slope_write_i) begin
        slope_r <= phase_rate_limit_select_i;
      end
      if (prog_write_i) begin
        prog_r <= programmable_phase_rate_value_i;
      end
    end
  end

  dmr_slope_limiter #(
    .PW(PW)
  ) u_slope (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .sel_i(slope_r),
    .prog_rate_i(prog_r),
    .target_i(target),
    .phase_o(output_phase_o)
  );

  // ----------------------------------------------------------------------
  // Secondary PLL
  // ----------------------------------------------------------------------
  logic pdn_r;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pdn_r <= dmr_pkg::DMR_PDN_RESET;
    end else if (pdn_write_i) begin
      pdn_r <= secondary_power_down_i;
    end
  end

  dmr_secondary_mode #(
    .FW(FW)
  ) u_sec (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .mode_sel_i(secondary_mode_select_i),
    .power_down_i(pdn_r),
    .averaging_i(secondary_holdover_averaging_i),
    .ref_selected_i(ref_selected_i),
    .ref_disqualified_i(ref_disqualified_i),
    .ref_preempted_i(ref_preempted_i),
    .ref_forced_move_i(ref_forced_move_i),
    .integral_freq_i(integral_freq_i),
    .state_o(secondary_state_o),
    .leave_ref_o(secondary_leave_ref_o),
    .hold_freq_o(secondary_hold_freq_o)
  );

  // ----------------------------------------------------------------------
  // Composite clock violations
  // ----------------------------------------------------------------------
  logic [1:0] viol_r;
  logic low_tone_r;
  logic irq_r;
  // Set wins over clear so a violation in the clearing cycle survives.
  wire logic [1:0] viol_nxt =
    (viol_r & ~violation_clear_i) | composite_bad_i;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      viol_r <= 2'h0;
      low_tone_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      viol_r <= viol_nxt;
      low_tone_r <= composite_low_tone_select_i;
      irq_r <= |(viol_nxt & violation_mask_i);
    end
  end

  // ----------------------------------------------------------------------
  // Per-input configuration store
  // ----------------------------------------------------------------------
  logic [3:0] sync_r [NIN];
  logic [3:0] freq_r [NIN];
  logic [1:0] hf_r [NIN];
  logic [14:0] integer_divider_r [NIN];
  logic [7:0] divlo_r [NIN];
  logic [15:0] num_r [NIN];
  logic [15:0] den_r [NIN];
  logic [1:0] byp_r [NIN];
  logic [1:0] sfreq_r;

  // Inputs 0 and 1 are the composite inputs; 2 to 7 are differential.
  function automatic logic is_comp(input logic [3:0] idx);
    is_comp = (idx < 4'h2);
  endfunction : is_comp

  function automatic logic is_diff(input logic [3:0] idx);
    is_diff = (idx >= 4'h2) && (idx < 4'h8);
  endfunction : is_diff

  function automatic logic freq_bad(input logic [3:0] c);
    freq_bad = !(c == dmr_pkg::DMR_FREQ_8K || c == dmr_pkg::DMR_FREQ_T1E1 ||
      c == dmr_pkg::DMR_FREQ_6M48 || c == dmr_pkg::DMR_FREQ_2K ||
      c == dmr_pkg::DMR_FREQ_4K || c == dmr_pkg::DMR_FREQ_1PPS ||
      c == dmr_pkg::DMR_FREQ_6M25);
  endfunction : freq_bad

  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_in
      wire logic hit = cfg_write_i && (cfg_input_i == 4'(gi));
      always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
          sync_r[gi] <= 4'h0;
          freq_r[gi] <= dmr_pkg::DMR_FREQ_8K;
          hf_r[gi] <= dmr_pkg::DMR_HF_BYPASS;
          integer_divider_r[gi] <= 15'h0000;
          divlo_r[gi] <= 8'h00;
          num_r[gi] <= 16'h0000;
          den_r[gi] <= 16'h0000;
          byp_r[gi] <= 2'h0;
        end else if (hit) begin
          unique case (cfg_field_i)
            F_SYNC: sync_r[gi] <= cfg_data_i[3:0];
            F_FREQ: freq_r[gi] <= cfg_data_i[3:0];
            F_HFDIV: hf_r[gi] <= cfg_data_i[1:0];
            F_DIVLO: divlo_r[gi] <= cfg_data_i[7:0];
            F_DIVHI: integer_divider_r[gi] <= {cfg_data_i[6:0], divlo_r[gi]};
            F_NUM: num_r[gi] <= cfg_data_i;
            F_DEN: den_r[gi] <= cfg_data_i;
            F_BYP: byp_r[gi] <= cfg_data_i[1:0];
          endcase
        end
      end
    end
  endgenerate

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sfreq_r <= 2'h0;
    end else if (cfg_write_i && cfg_field_i == F_SYNC) begin
      sfreq_r <= cfg_data_i[9:8];
    end
  end

  // ----------------------------------------------------------------------
  // Read selection
  // ----------------------------------------------------------------------
  wire logic rd_ok = (rd_input_i < 4'(NIN));
  wire logic [3:0] ri = rd_ok ? rd_input_i : 4'h0;
  wire logic rd_comp = is_comp(ri);
  wire logic [3:0] fsel = rd_comp ? dmr_pkg::DMR_FREQ_8K : freq_r[ri];
  wire logic [1:0] hsel = is_diff(ri) ? hf_r[ri] : dmr_pkg::DMR_HF_BYPASS;
  // A zero bypass field with bypass HF divider means the whole chain is off.
  wire logic byp = rd_comp ||
    (hsel == dmr_pkg::DMR_HF_BYPASS && byp_r[ri] == 2'h0);

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_source_o <= 4'h0;
      sync_freq_o <= 2'h0;
      freq_code_o <= 4'h0;
      freq_reserved_o <= 1'b0;
      high_freq_divide_select_o <= 2'h0;
      integer_divide_factor_o <= 15'h0000;
      prediv_bypass_o <= 1'b1;
      frac_num_o <= 16'h0000;
      frac_den_o <= 16'h0000;
    end else begin
      sync_source_o <= sync_r[ri];
      sync_freq_o <= sfreq_r;
      freq_code_o <= fsel;
      freq_reserved_o <= freq_bad(fsel);
      high_freq_divide_select_o <= hsel;
      integer_divide_factor_o <= integer_divider_r[ri];
      prediv_bypass_o <= byp;
      frac_num_o <= num_r[ri];
      frac_den_o <= den_r[ri];
    end
  end

  // ----------------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      compensation_o <= '0;
      slope_select_o <= dmr_pkg::DMR_SLOPE_RESET;
      prog_rate_o <= dmr_pkg::DMR_PROG_RATE_RESET;
      secondary_power_down_o <= dmr_pkg::DMR_PDN_RESET;
    end else begin
      compensation_o <= comp_r;
      slope_select_o <= slope_r;
      prog_rate_o <= prog_r;
      secondary_power_down_o <= pdn_r;
    end
  end

  assign composite_a_violation_flag_o = viol_r[0];
  assign composite_b_violation_flag_o = viol_r[1];
  assign composite_low_tone_o = low_tone_r;
  assign interrupt_o = irq_r;
endmodule : dmr_ref_path
`default_nettype wire

// ### bench/dmr_ref_path_props.sv
// Purpose: Port-level assertions for the reference path controller.
// Assumes: Sees only the top module ports; one clock domain.
// Notes: Bound to the top module from the testbench file.
`timescale 1ns/1ps
`default_nettype none
module dmr_props #(
  parameter int PW = 24
) (
  input wire logic clock_i, rstn_i, seamless_enable_i, seamless_freeze_i,
  input wire logic slope_write_i, pdn_write_i, ref_selected_i,
  input wire logic seamless_switch_event_o, secondary_power_down_o,
  input wire logic composite_a_violation_flag_o, interrupt_o,
  input wire logic composite_b_violation_flag_o,
  input wire logic [3:0] primary_ref_i,
  input wire logic signed [PW-1:0] ref_phase_i, compensation_o,
  input wire logic signed [PW-1:0] output_phase_o,
  input wire logic [2:0] phase_rate_limit_select_i, slope_select_o,
  input wire logic [2:0] secondary_mode_select_i,
  input wire logic [23:0] prog_rate_o,
  input wire logic [1:0] secondary_state_o, violation_mask_i
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  AST_EVT_ON_CHANGE: assert property (
    seamless_enable_i && !seamless_freeze_i && $past(rstn_i) &&
    primary_ref_i != $past(primary_ref_i) |=> seamless_switch_event_o)
    else $error("switch event missing after reference change");
  AST_FREEZE_NO_EVT: assert property (
    seamless_freeze_i |=> !seamless_switch_event_o)
    else $error("switch event raised while frozen");
  AST_COMP_VALUE: assert property (
    seamless_switch_event_o && seamless_enable_i && !seamless_freeze_i |=>
    compensation_o == $past(ref_phase_i, 2) - $past(output_phase_o, 2))
    else $error("compensation does not match measured phase");
  AST_SLOPE_LOAD: assert property (
    slope_write_i |=> ##1
    slope_select_o == $past(phase_rate_limit_select_i, 2))
    else $error("slope select not loaded");
  AST_PROG_ZERO_HOLD: assert property (
    slope_select_o == 3'h7 && prog_rate_o == 24'h000000 |->
    $stable(output_phase_o))
    else $error("output phase moved with zero programmed rate");
  AST_FORCED_FREE: assert property (
    (secondary_power_down_o || $past(secondary_mode_select_i) == 3'h1) |->
    secondary_state_o == 2'h0)
    else $error("secondary not in free run");
  AST_AUTO_LOCK: assert property (
    secondary_mode_select_i == 3'h0 && !secondary_power_down_o &&
    !$past(pdn_write_i) && secondary_state_o == 2'h0 && ref_selected_i |=>
    secondary_state_o == 2'h1)
    else $error("secondary did not lock on selection");
  AST_IRQ_MASK: assert property (
    interrupt_o == |({composite_b_violation_flag_o,
    composite_a_violation_flag_o} & $past(violation_mask_i)))
    else $error("interrupt does not follow masked flags");
endmodule : dmr_props
`default_nettype wire

// ### bench/testbench.sv
// Purpose: Self-checking bench for the reference path controller.
// Assumes: Inputs driven by non-blocking assignment at the rising edge.
// Notes: Checks are made at the falling edge, after updates settle.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock_i, rstn_i, seamless_enable_i, seamless_freeze_i;
  logic primary_in_holdover_i, primary_in_free_run_i, slope_write_i;
  logic prog_write_i, pdn_write_i, secondary_power_down_i, cfg_write_i;
  logic secondary_holdover_averaging_i, ref_selected_i, ref_disqualified_i;
  logic ref_preempted_i, ref_forced_move_i, composite_low_tone_select_i;
  logic [3:0] primary_ref_i, cfg_input_i, rd_input_i, sync_source_o;
  logic [3:0] freq_code_o;
  logic signed [23:0] ref_phase_i, integral_freq_i, compensation_o;
  logic signed [23:0] output_phase_o, secondary_hold_freq_o;
  logic [2:0] phase_rate_limit_select_i, secondary_mode_select_i;
  logic [2:0] cfg_field_i, slope_select_o;
  logic [23:0] programmable_phase_rate_value_i, prog_rate_o;
  logic [1:0] composite_bad_i, violation_clear_i, violation_mask_i;
  logic [1:0] secondary_state_o, sync_freq_o, high_freq_divide_select_o;
  logic [15:0] cfg_data_i, frac_num_o, frac_den_o;
  logic [14:0] integer_divide_factor_o;
  logic seamless_switch_event_o, secondary_power_down_o, interrupt_o;
  logic secondary_leave_ref_o, composite_a_violation_flag_o;
  logic composite_b_violation_flag_o, composite_low_tone_o;
  logic freq_reserved_o, prediv_bypass_o;
  int fails = 0;
  int n_compared = 0;
  dmr_ref_path #(.NIN(14), .PW(24), .FW(24)) i_dmr_ref_path (.*);
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  task automatic chk(input string s, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic cy(input int n);
    repeat (n) @(posedge clock_i);
    @(negedge clock_i);
  endtask : cy
  task automatic wr(input logic [3:0] n, input logic [2:0] f,
                    input logic [15:0] d);
    @(posedge clock_i);
    cfg_write_i <= 1'b1;
    cfg_input_i <= n;
    cfg_field_i <= f;
    cfg_data_i <= d;
    @(posedge clock_i);
    cfg_write_i <= 1'b0;
  endtask : wr
  task automatic t_seam;
    @(posedge clock_i);
    seamless_enable_i <= 1'b1;
    ref_phase_i <= 24'h000100;
    primary_ref_i <= 4'h5;
    cy(1); chk("event", 1, seamless_switch_event_o);
    cy(1); chk("comp", 24'h000100, compensation_o);
    @(posedge clock_i);
    seamless_freeze_i <= 1'b1;
    primary_ref_i <= 4'h6;
    ref_phase_i <= 24'h000200;
    cy(2); chk("frozen event", 0, seamless_switch_event_o);
    chk("frozen comp", 24'h000100, compensation_o);
    @(posedge clock_i);
    seamless_freeze_i <= 1'b0;
    primary_in_holdover_i <= 1'b1;
    @(posedge clock_i);
    primary_in_holdover_i <= 1'b0;
    cy(1); chk("exit event", 1, seamless_switch_event_o);
    @(posedge clock_i);
    seamless_enable_i <= 1'b0;
    cy(2); chk("disabled comp", 0, compensation_o);
    $display("seamless test done");
  endtask : t_seam
  task automatic t_sec;
    logic [2:0] m [3] = '{3'h4, 3'h2, 3'h1};
    logic [1:0] e [3] = '{2'h1, 2'h3, 2'h0};
    @(posedge clock_i);
    pdn_write_i <= 1'b1;
    @(posedge clock_i);
    pdn_write_i <= 1'b0;
    cy(1); chk("power down", 0, secondary_power_down_o);
    for (int i = 0; i < 3; i++) begin
      @(posedge clock_i);
      secondary_mode_select_i <= m[i];
      cy(1); chk("forced state", e[i], secondary_state_o);
    end
    @(posedge clock_i);
    secondary_mode_select_i <= 3'h0;
    ref_selected_i <= 1'b1;
    cy(1); chk("auto lock", 2'h1, secondary_state_o);
    @(posedge clock_i);
    ref_disqualified_i <= 1'b1;
    cy(1); chk("leave", 1, secondary_leave_ref_o);
    chk("holdover", 2'h3, secondary_state_o);
    @(posedge clock_i);
    ref_disqualified_i <= 1'b0;
    $display("secondary test done");
  endtask : t_sec
  task automatic t_comp;
    @(posedge clock_i);
    composite_bad_i <= 2'h1;
    @(posedge clock_i);
    composite_bad_i <= 2'h0;
    @(negedge clock_i);
    chk("flag a", 1, composite_a_violation_flag_o);
    chk("irq masked", 0, interrupt_o);
    @(posedge clock_i);
    violation_mask_i <= 2'h1;
    cy(1); chk("irq", 1, interrupt_o);
    $display("composite test done");
  endtask : t_comp
  task automatic t_cfg;
    @(posedge clock_i);
    rd_input_i <= 4'h3;
    for (int c = 0; c < 16; c++) begin
      wr(4'h3, 3'h1, 16'(c));
      cy(1); chk("freq", c, freq_code_o);
      chk("rsv", !(c inside {0,1,2,9,10,11,12}), freq_reserved_o);
    end
    wr(4'h3, 3'h3, 16'h0034);
    cy(1); chk("staged", 0, integer_divide_factor_o);
    wr(4'h3, 3'h4, 16'h0012);
    cy(1); chk("factor", 15'h1234, integer_divide_factor_o);
    wr(4'h3, 3'h5, 16'hBEEF);
    wr(4'h3, 3'h6, 16'h1234);
    cy(1); chk("num", 16'hBEEF, frac_num_o);
    chk("den", 16'h1234, frac_den_o);
    wr(4'h3, 3'h0, 16'h020A);
    cy(1); chk("sync", 4'hA, sync_source_o);
    chk("sync freq", 2'h2, sync_freq_o);
    chk("bypass", 1, prediv_bypass_o);
    wr(4'h0, 3'h1, 16'h0005);
    rd_input_i <= 4'h0;
    cy(1); chk("comp freq", 0, freq_code_o);
    chk("comp bypass", 1, prediv_bypass_o);
    wr(4'h4, 3'h2, 16'h0001);
    rd_input_i <= 4'h4;
    cy(1); chk("hf", 2'h1, high_freq_divide_select_o);
    chk("hf bypass", 0, prediv_bypass_o);
    $display("config test done");
  endtask : t_cfg
  task automatic t_slope;
    for (int c = 0; c < 8; c++) begin
      @(posedge clock_i);
      slope_write_i <= 1'b1;
      phase_rate_limit_select_i <= 3'(c);
      @(posedge clock_i);
      slope_write_i <= 1'b0;
      cy(1); chk("slope", c, slope_select_o);
    end
    @(posedge clock_i);
    prog_write_i <= 1'b1;
    programmable_phase_rate_value_i <= 24'hFFFFFF;
    @(posedge clock_i);
    prog_write_i <= 1'b0;
    cy(1); chk("prog", 24'hFFFFFF, prog_rate_o);
    chk("phase", 24'h000200, output_phase_o);
    $display("slope test done");
  endtask : t_slope
  task automatic close_out;
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (4000) @(posedge clock_i);
    fails++;
    close_out;
  end
  initial begin
    {rstn_i, seamless_enable_i, seamless_freeze_i, primary_in_holdover_i,
     primary_in_free_run_i, slope_write_i, prog_write_i, pdn_write_i,
     secondary_power_down_i, cfg_write_i, secondary_holdover_averaging_i,
     ref_selected_i, ref_disqualified_i, ref_preempted_i, ref_forced_move_i,
     composite_low_tone_select_i, primary_ref_i, cfg_input_i, rd_input_i,
     ref_phase_i, integral_freq_i, phase_rate_limit_select_i,
     secondary_mode_select_i, cfg_field_i, programmable_phase_rate_value_i,
     composite_bad_i, violation_clear_i, violation_mask_i, cfg_data_i} = '0;
    repeat (8) @(posedge clock_i);
    rstn_i <= 1'b1;
    cy(0); chk("slope rst", 3'h7, slope_select_o);
    chk("prog rst", 0, prog_rate_o);
    chk("pdn rst", 1, secondary_power_down_o);
    t_seam;
    t_sec;
    t_comp;
    t_cfg;
    t_slope;
    close_out;
  end
endmodule : testbench
bind dmr_ref_path dmr_props #(.PW(PW)) i_dmr_props (.*);
`default_nettype wire
